// >>> src/cpurf_top.sv
// cpu register file: banked registers, pointers, flags, fast-irq save
// Operation
// (RULE_01) two full register banks
// (RULE_02) data regs whole or per half
// (RULE_03) data regs 0,1 byte writable
// (RULE_04) address regs form indirect addresses
// (RULE_05) pc holds next instruction address
// (RULE_06) vector base locates vector table
// (RULE_07) flag bit 7 selects stack pointer
// (RULE_08) interrupt or low soft vector clears stack select
// (RULE_09) carry takes carry/borrow/shift-out
// (RULE_10) zero flag marks zero result
// (RULE_11) sign flag marks negative result
// (RULE_12) overflow flag marks overflowed result
// (RULE_13) bank flag picks active bank
// (RULE_14) irq enable gates, cleared on accept
// (RULE_15) admit only levels above priority field
// (RULE_16) priority seven admits nothing
// (RULE_17) fp underflow on underflow or subnormal
// (RULE_18) fp overflow on overflow or subnormal
// (RULE_19) two-bit field selects fp rounding
// (RULE_20) radix bit picks fixed-point product slice
// (RULE_21) debug flag must be written zero
// (RULE_22) fast interrupt saves flags and pc, jumps
// (RULE_23) push/pop move only selected stack pointer
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module cpurf_top
    import cpurf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // datapath register port
    input wire logic regWrEn,
    input wire logic [3:0] regWrIdx,
    input wire logic [2:0] regWrMode,
    input wire logic [31:0] regWrData,
    input wire logic [3:0] regRdIdx,
    output logic [31:0] regRdData,
    // address generation
    input wire logic [1:0] agenBase,
    input wire logic agenRelative,
    input wire logic [31:0] agenDisp,
    output logic [31:0] agenAddr,
    // program counter and stack
    input wire logic pcLoadEn,
    input wire logic [31:0] pcLoadVal,
    output logic [31:0] pcOut,
    input wire logic pushEn,
    input wire logic popEn,
    output logic [31:0] stackPtr,
    // alu, fp and bank flag updates
    input wire logic aluFlagEn,
    input wire logic aluCarry,
    input wire logic aluZero,
    input wire logic aluSign,
    input wire logic aluOvf,
    input wire logic fpFlagEn,
    input wire logic fpUnder,
    input wire logic fpOver,
    input wire logic bankSelEn,
    input wire logic bankSelVal,
    // interrupt sequencing
    input wire logic intAccept,
    input wire logic intHw,
    input wire logic [7:0] intSwNum,
    input wire logic fastIntEn,
    input wire logic fastRetEn,
    input wire logic irqReqEn,
    input wire logic [2:0] irqReqLevel,
    output logic irqAdmit,
    // flag and vector views
    output logic [31:0] flagsOut,
    output logic [31:0] vecBaseOut,
    output logic [1:0] roundMode,
    output logic radixPoint
);
    // ****
    // helpers
    // ****
    // lane mask of a datapath write; zero = refused
    function automatic logic [31:0] laneMask(input logic [2:0] mode, input logic [3:0] idx);
        logic byteOk;
        byteOk = (idx == IDX_DATA0) || (idx == IDX_DATA1);
        unique case (mode)
            WR_WORD: laneMask = 32'hFFFF_FFFF;
            WR_LO16: laneMask = 32'h0000_FFFF; // [RULE_02]
            WR_HI16: laneMask = 32'hFFFF_0000; // [RULE_02]
            WR_BYTE0: laneMask = byteOk ? 32'h0000_00FF : 32'h0000_0000; // [RULE_03]
            WR_BYTE1: laneMask = byteOk ? 32'h0000_FF00 : 32'h0000_0000; // [RULE_03]
            WR_BYTE2: laneMask = byteOk ? 32'h00FF_0000 : 32'h0000_0000; // [RULE_03]
            WR_BYTE3: laneMask = byteOk ? 32'hFF00_0000 : 32'h0000_0000; // [RULE_03]
            default: laneMask = 32'h0000_0000;
        endcase
    endfunction

    // lanes aligned: data byte n lands in byte n
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction

    // apb address inside a bank window
    function automatic logic bankHit(input logic [7:0] addr);
        bankHit = (addr[7] == 1'b0) && (addr[5:2] <= IDX_LAST) && (addr[1:0] == 2'b00);
    endfunction

    // ****
    // state
    // ****
    logic [31:0] bankRegs [2][NUM_BANK_REGS];
    logic [31:0] pc_ff;
    logic [31:0] vecBase_ff;
    logic [31:0] userSp_ff;
    logic [31:0] irqSp_ff;
    logic [31:0] savedFlags_ff;
    logic [31:0] savedPc_ff;
    logic [31:0] fastVec_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] regRdData_ff;
    logic [31:0] agenAddr_ff;
    logic irqAdmit_ff;
    logic [31:0] flagsView_ff;

    cpurf_flag_if flagBus();

    logic bank;
    logic stackSel;
    logic [2:0] cpu_priority_level;
    logic apbWr;
    logic apbAccess;
    logic [3:0] apbIdx;
    logic apbBank;
    logic [31:0] wrMask;

    assign bank = flagBus.flags[FLG_BANK]; // [RULE_13]
    assign stackSel = flagBus.flags[FLG_STACK_SEL]; // [RULE_07]
    assign cpu_priority_level = flagBus.flags[FLG_IPL_HI:FLG_IPL_LO];
    assign apbIdx = paddr[5:2];
    assign apbBank = paddr[6];
    assign wrMask = laneMask(regWrMode, regWrIdx);

    // ****
    // apb slave
    // ****
    // one wait state before pready
    assign apbAccess = psel && penable && !pready_ff;
    assign apbWr = psel && penable && pready_ff && pwrite && !pslverr_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= RESET_WORD;
        end else begin
            pready_ff <= apbAccess;
            pslverr_ff <= 1'b0;
            prdata_ff <= RESET_WORD;
            if (apbAccess) begin
                pslverr_ff <= !bankHit(paddr) && !(paddr >= OFS_PC && paddr <= OFS_FAST_VEC
                              && paddr[1:0] == 2'b00);
                if (!pwrite && bankHit(paddr)) begin
                    prdata_ff <= bankRegs[apbBank][apbIdx];
                end else if (!pwrite) begin
                    unique case (paddr)
                        OFS_PC: prdata_ff <= pc_ff;
                        OFS_VEC_BASE: prdata_ff <= vecBase_ff;
                        OFS_USER_SP: prdata_ff <= userSp_ff;
                        OFS_IRQ_SP: prdata_ff <= irqSp_ff;
                        OFS_FLAGS: prdata_ff <= flagBus.flags;
                        OFS_SAVED_FLAGS: prdata_ff <= savedFlags_ff;
                        OFS_SAVED_PC: prdata_ff <= savedPc_ff;
                        OFS_FAST_VEC: prdata_ff <= fastVec_ff;
                        default: prdata_ff <= RESET_WORD;
                    endcase
                end
            end
        end
    end

    // ****
    // banked general registers
    // ****
    // datapath write last: running core wins a clash
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int b = 0; b < 2; b++) begin
                for (int r = 0; r < NUM_BANK_REGS; r++) begin
                    bankRegs[b][r] <= RESET_WORD; // [RULE_01]
                end
            end
        end else begin
            if (apbWr && bankHit(paddr)) begin
                bankRegs[apbBank][apbIdx] <= pwdata;
            end
            if (regWrEn && regWrIdx <= IDX_LAST) begin
                bankRegs[bank][regWrIdx] <= merge(bankRegs[bank][regWrIdx], regWrData,
                                                  wrMask); // [RULE_01] [RULE_02] [RULE_03]
            end
        end
    end

    // datapath read of the active bank
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData_ff <= RESET_WORD;
        end else begin
            regRdData_ff <= (regRdIdx <= IDX_LAST) ? bankRegs[bank][regRdIdx] : RESET_WORD;
        end
    end

    // indirect or relative address from an address register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            agenAddr_ff <= RESET_WORD;
        end else begin
            agenAddr_ff <= bankRegs[bank][IDX_ADDR0 + {2'b00, agenBase}]
                           + (agenRelative ? agenDisp : RESET_WORD); // [RULE_04]
        end
    end

    // ****
    // program counter and fast interrupt save
    // ****
    // fast entry beats fast return beats load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_ff <= RESET_PC;
        end else if (fastIntEn) begin
            pc_ff <= fastVec_ff; // [RULE_22]
        end else if (fastRetEn) begin
            pc_ff <= savedPc_ff;
        end else if (pcLoadEn) begin
            pc_ff <= pcLoadVal; // [RULE_05]
        end else if (apbWr && paddr == OFS_PC) begin
            pc_ff <= pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            savedFlags_ff <= RESET_WORD;
            savedPc_ff <= RESET_WORD;
            fastVec_ff <= RESET_WORD;
        end else begin
            if (apbWr && paddr == OFS_SAVED_FLAGS) begin
                savedFlags_ff <= pwdata;
            end
            if (apbWr && paddr == OFS_SAVED_PC) begin
                savedPc_ff <= pwdata;
            end
            if (apbWr && paddr == OFS_FAST_VEC) begin
                fastVec_ff <= pwdata;
            end
            if (fastIntEn) begin
                savedFlags_ff <= flagBus.flags; // [RULE_22]
                savedPc_ff <= pc_ff; // [RULE_22]
            end
        end
    end

    // relocatable vector table base
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vecBase_ff <= RESET_WORD;
        end else if (apbWr && paddr == OFS_VEC_BASE) begin
            vecBase_ff <= pwdata; // [RULE_06]
        end
    end

    // ****
    // stack pointers
    // ****
    // push wins over pop; software keeps pointers aligned
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            userSp_ff <= RESET_WORD;
            irqSp_ff <= RESET_WORD;
        end else begin
            if (apbWr && paddr == OFS_USER_SP) begin
                userSp_ff <= pwdata;
            end
            if (apbWr && paddr == OFS_IRQ_SP) begin
                irqSp_ff <= pwdata;
            end
            if (pushEn || popEn) begin
                if (stackSel) begin
                    userSp_ff <= pushEn ? userSp_ff - STACK_STEP
                                        : userSp_ff + STACK_STEP; // [RULE_23]
                end else begin
                    irqSp_ff <= pushEn ? irqSp_ff - STACK_STEP
                                       : irqSp_ff + STACK_STEP; // [RULE_23]
                end
            end
        end
    end

    // ****
    // flag unit
    // ****
    // debug bit stored as written; kept zero by software [RULE_21]
    assign flagBus.swWrEn = apbWr && paddr == OFS_FLAGS;
    assign flagBus.swWrData = pwdata;
    assign flagBus.aluEn = aluFlagEn;
    assign flagBus.carry = aluCarry;
    assign flagBus.zero = aluZero;
    assign flagBus.sign = aluSign;
    assign flagBus.ovf = aluOvf;
    assign flagBus.fpEn = fpFlagEn;
    assign flagBus.fpUnder = fpUnder;
    assign flagBus.fpOver = fpOver;
    assign flagBus.bankEn = bankSelEn;
    assign flagBus.bankVal = bankSelVal;
    assign flagBus.intAccept = intAccept || fastIntEn; // [RULE_14]
    assign flagBus.intHw = intHw || fastIntEn; // [RULE_08]
    assign flagBus.intSwNum = intSwNum;
    assign flagBus.restoreEn = fastRetEn && !fastIntEn;
    assign flagBus.restoreVal = savedFlags_ff;

    cpurf_flags u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .fl(flagBus.unit)
    );

    // ****
    // interrupt admission and flag views
    // ****
    // admit only above the level, never at seven
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqAdmit_ff <= 1'b0;
        end else begin
            irqAdmit_ff <= irqReqEn && flagBus.flags[FLG_IRQ_EN] // [RULE_14]
                           && (irqReqLevel > cpu_priority_level) // [RULE_15]
                           && (cpu_priority_level != IPL_ALL_BLOCKED); // [RULE_16]
        end
    end

    // copy so outputs leave a flip-flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flagsView_ff <= FLAGS_RST;
        end else begin
            flagsView_ff <= flagBus.flags;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign regRdData = regRdData_ff;
    assign agenAddr = agenAddr_ff;
    assign pcOut = pc_ff;
    assign stackPtr = stackSel ? userSp_ff : irqSp_ff; // [RULE_07]
    assign irqAdmit = irqAdmit_ff;
    assign flagsOut = flagsView_ff;
    assign vecBaseOut = vecBase_ff;
    assign roundMode = flagsView_ff[FLG_RND_HI:FLG_RND_LO]; // [RULE_19]
    assign radixPoint = flagsView_ff[FLG_RADIX]; // [RULE_20]
endmodule

// >>> src/cpurf_pkg.sv
// constants shared by the cpu register file and its flag unit
package cpurf_pkg;
    // ****
    // register file geometry
    // ****
    localparam int NUM_BANK_REGS = 10;
    localparam logic [3:0] IDX_DATA0 = 4'h0;
    localparam logic [3:0] IDX_DATA1 = 4'h1;
    localparam logic [3:0] IDX_ADDR0 = 4'h4;
    localparam logic [3:0] IDX_LAST = 4'h9;
    localparam logic [31:0] STACK_STEP = 32'h0000_0004;
    localparam logic [31:0] RESET_PC = 32'h0000_0000;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // ****
    // apb byte addresses
    // ****
    localparam logic [7:0] OFS_BANK0 = 8'h00;
    localparam logic [7:0] OFS_BANK1 = 8'h40;
    localparam logic [7:0] OFS_PC = 8'h80;
    localparam logic [7:0] OFS_VEC_BASE = 8'h84;
    localparam logic [7:0] OFS_USER_SP = 8'h88;
    localparam logic [7:0] OFS_IRQ_SP = 8'h8C;
    localparam logic [7:0] OFS_FLAGS = 8'h90;
    localparam logic [7:0] OFS_SAVED_FLAGS = 8'h94;
    localparam logic [7:0] OFS_SAVED_PC = 8'h98;
    localparam logic [7:0] OFS_FAST_VEC = 8'h9C;

    // ****
    // processor_flags field positions
    // ****
    localparam int FLG_CARRY = 0;
    localparam int FLG_DEBUG = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_SIGN = 3;
    localparam int FLG_BANK = 4;
    localparam int FLG_OVF = 5;
    localparam int FLG_IRQ_EN = 6;
    localparam int FLG_STACK_SEL = 7;
    localparam int FLG_FP_UNDER = 8;
    localparam int FLG_FP_OVER = 9;
    localparam int FLG_IPL_LO = 12;
    localparam int FLG_IPL_HI = 14;
    localparam int FLG_RADIX = 16;
    localparam int FLG_RND_LO = 18;
    localparam int FLG_RND_HI = 19;
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] FLAGS_MASK = 32'h000D_73FF;
    localparam logic [2:0] IPL_ALL_BLOCKED = 3'h7;
    localparam logic [7:0] SW_INT_LAST_SYS = 8'h7F;

    // ****
    // datapath write lane modes
    // ****
    typedef enum logic [2:0] {
        WR_WORD = 3'h0,
        WR_LO16 = 3'h1,
        WR_HI16 = 3'h2,
        WR_BYTE0 = 3'h3,
        WR_BYTE1 = 3'h4,
        WR_BYTE2 = 3'h5,
        WR_BYTE3 = 3'h6
    } cpurf_wr_mode_t;
endpackage

// >>> src/cpurf_flag_if.sv
// carrier between the register file top and its flag unit
`timescale 1ns/1ps
interface cpurf_flag_if;
    logic swWrEn;
    logic [31:0] swWrData;
    logic aluEn;
    logic carry;
    logic zero;
    logic sign;
    logic ovf;
    logic fpEn;
    logic fpUnder;
    logic fpOver;
    logic bankEn;
    logic bankVal;
    logic intAccept;
    logic intHw;
    logic [7:0] intSwNum;
    logic restoreEn;
    logic [31:0] restoreVal;
    logic [31:0] flags;

    modport ctrl (
        output swWrEn, swWrData, aluEn, carry, zero, sign, ovf, fpEn, fpUnder, fpOver,
        output bankEn, bankVal, intAccept, intHw, intSwNum, restoreEn, restoreVal,
        input flags
    );
    modport unit (
        input swWrEn, swWrData, aluEn, carry, zero, sign, ovf, fpEn, fpUnder, fpOver,
        input bankEn, bankVal, intAccept, intHw, intSwNum, restoreEn, restoreVal,
        output flags
    );
endinterface

// >>> src/cpurf_flags.sv
// processor flag register with its hardware update paths
`timescale 1ns/1ps
module cpurf_flags
    import cpurf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link to the register file
    cpurf_flag_if.unit fl
);
    logic [31:0] flags_ff;

    // ****
    // flag state
    // ****
    // later assignments win: hardware beats software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_ff <= FLAGS_RST;
        end else if (fl.restoreEn) begin
            flags_ff <= fl.restoreVal & FLAGS_MASK;
        end else begin
            if (fl.swWrEn) begin
                flags_ff <= fl.swWrData & FLAGS_MASK; // reserved bits stay zero
            end
            if (fl.aluEn) begin
                flags_ff[FLG_CARRY] <= fl.carry; // [RULE_09]
                flags_ff[FLG_ZERO] <= fl.zero; // [RULE_10]
                flags_ff[FLG_SIGN] <= fl.sign; // [RULE_11]
                flags_ff[FLG_OVF] <= fl.ovf; // [RULE_12]
            end
            if (fl.fpEn) begin
                flags_ff[FLG_FP_UNDER] <= fl.fpUnder; // [RULE_17]
                flags_ff[FLG_FP_OVER] <= fl.fpOver; // [RULE_18]
            end
            if (fl.bankEn) begin
                flags_ff[FLG_BANK] <= fl.bankVal; // [RULE_13]
            end
            if (fl.intAccept) begin
                flags_ff[FLG_IRQ_EN] <= 1'b0; // [RULE_14]
                if (fl.intHw || fl.intSwNum <= SW_INT_LAST_SYS) begin
                    flags_ff[FLG_STACK_SEL] <= 1'b0; // [RULE_08]
                end
            end
        end
    end

    assign fl.flags = flags_ff;
endmodule

// >>> bench/cpurf_alu_model.sv
// far-side alu model: adds two words, strobes flags
`timescale 1ns/1ps
module cpurf_alu_model
    import cpurf_pkg::*;
(
    // clock and command
    input wire logic clk,
    input wire logic go,
    input wire logic [31:0] opA,
    input wire logic [31:0] opB,
    // flag strobe to the register file
    output logic aluFlagEn,
    output logic aluCarry,
    output logic aluZero,
    output logic aluSign,
    output logic aluOvf
);
    // ****
    // one addition per command
    // ****
    logic [32:0] sum;
    assign sum = {1'h0, opA} + {1'h0, opB};
    // flags one edge after go
    always_ff @(posedge clk) begin
        aluFlagEn <= go;
        aluCarry <= sum[32];
        aluZero <= sum[31:0] == 32'h0;
        aluSign <= sum[31];
        aluOvf <= (opA[31] == opB[31]) && (sum[31] != opA[31]);
    end
endmodule

// >>> bench/cpurf_top_assertions.sv
// concurrent checks on the register file top ports
`timescale 1ns/1ps
module cpurf_top_assertions
    import cpurf_pkg::*;
(
    // clock, reset, apb
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // datapath strobes
    input wire logic pcLoadEn,
    input wire logic [31:0] pcLoadVal,
    input wire logic pushEn,
    input wire logic popEn,
    input wire logic aluFlagEn,
    input wire logic aluCarry,
    input wire logic aluZero,
    input wire logic aluSign,
    input wire logic aluOvf,
    input wire logic fpFlagEn,
    input wire logic fpUnder,
    input wire logic fpOver,
    input wire logic bankSelEn,
    input wire logic bankSelVal,
    input wire logic intAccept,
    input wire logic intHw,
    input wire logic fastIntEn,
    input wire logic fastRetEn,
    input wire logic irqReqEn,
    input wire logic [2:0] irqReqLevel,
    // observed outputs
    input wire logic [31:0] pcOut,
    input wire logic [31:0] stackPtr,
    input wire logic irqAdmit,
    input wire logic [31:0] flagsOut
);
    // ****
    // timing and flag relations
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // flagsOut trails flags by one edge
    AST_APB_ANSWER:
    assert property (psel && !penable ##1 psel && penable |=> pready)
        else $error("apb answer missing");
    AST_ALU_FLAGS:
    assert property (aluFlagEn && !fastRetEn |=> ##1 {flagsOut[5], flagsOut[3:2],
        flagsOut[0]} == $past({aluOvf, aluSign, aluZero, aluCarry}, 2))
        else $error("alu flags not loaded");
    AST_FP_FLAGS:
    assert property (fpFlagEn && !fastRetEn |=> ##1 flagsOut[9:8] == $past({fpOver, fpUnder}, 2))
        else $error("fp flags not loaded");
    AST_BANK_FLAG:
    assert property (bankSelEn && !fastRetEn |=> ##1 flagsOut[4] == $past(bankSelVal, 2))
        else $error("bank flag not loaded");
    AST_INT_CLEAR:
    assert property ((intAccept && intHw || fastIntEn) && !fastRetEn |=> ##1 flagsOut[7:6] == 2'h0)
        else $error("accept left enable or stack select set");
    AST_ADMIT:
    assert property (irqAdmit == ($past(irqReqEn) && flagsOut[6] && flagsOut[14:12] != 3'h7
        && $past(irqReqLevel) > flagsOut[14:12]))
        else $error("admit decision wrong");
    AST_STACK_STEP:
    assert property ((pushEn || popEn) && !(psel || intAccept || fastIntEn || fastRetEn) |=>
        stackPtr == ($past(pushEn) ? $past(stackPtr) - 32'h4 : $past(stackPtr) + 32'h4))
        else $error("stack pointer step wrong");
    AST_PC_LOAD:
    assert property (pcLoadEn && !fastIntEn && !fastRetEn |=> pcOut == $past(pcLoadVal))
        else $error("pc load lost");
endmodule
bind cpurf_top cpurf_top_assertions cpurf_top_assertions_i (.*);

// >>> bench/test_cpurf_top.sv
// self-checking bench for the cpu register file top
`timescale 1ns/1ps
module test_cpurf_top;
    import cpurf_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w, r; logic e;} cpurf_row_t;
    logic clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, pready, pslverr, err;
    logic regWrEn = '0, agenRelative = '0, pcLoadEn = '0, pushEn = '0, popEn = '0, aluGo = '0;
    logic fpFlagEn = '0, fpUnder = '0, fpOver = '0, bankSelEn = '0, bankSelVal = '0;
    logic intAccept = '0, intHw = '0, fastIntEn = '0, fastRetEn = '0, irqReqEn = '0;
    logic irqAdmit, radixPoint, aluFlagEn, aluCarry, aluZero, aluSign, aluOvf;
    logic [1:0] agenBase = '0, roundMode;
    logic [2:0] regWrMode = '0, irqReqLevel = '0;
    logic [3:0] regWrIdx = '0, regRdIdx = '0;
    logic [7:0] paddr = '0, intSwNum = '0;
    logic [31:0] pwdata = '0, regWrData = '0, agenDisp = '0, pcLoadVal = '0, opA = '0, opB = '0;
    logic [31:0] prdata, regRdData, agenAddr, pcOut, stackPtr, flagsOut, vecBaseOut, rd;
    int fails = 0, samplesChecked = 0, cyc = 0;
    // ordinary cases: address, write value, read-back, error flag
    cpurf_row_t rows [9] = '{
        '{OFS_BANK0, 32'h12345678, 32'h12345678, 1'h0},
        '{8'h44, 32'h9ABCDEF0, 32'h9ABCDEF0, 1'h0},
        '{OFS_PC, 32'h1000, 32'h1000, 1'h0},
        '{OFS_VEC_BASE, 32'hFFFF0000, 32'hFFFF0000, 1'h0},
        '{OFS_USER_SP, 32'h100, 32'h100, 1'h0},
        '{OFS_IRQ_SP, 32'h200, 32'h200, 1'h0},
        '{OFS_FAST_VEC, 32'h5000, 32'h5000, 1'h0},
        '{OFS_FLAGS, 32'hFFFFFFFD, 32'h000D73FD, 1'h0},
        '{8'hA0, 32'h1, 32'h0, 1'h1}
    };
    cpurf_top cpurf_top_i (.*);
    cpurf_alu_model cpurf_alu_model_i (.clk, .go(aluGo), .opA, .opB, .aluFlagEn, .aluCarry,
        .aluZero, .aluSign, .aluOvf);
    // ****
    // helpers
    // ****
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samplesChecked++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer; request held until pready is sampled
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic regw(input logic [3:0] i, input logic [2:0] m, input logic [31:0] d, e);
        @(posedge clk);
        regWrEn <= 1'h1;
        regWrIdx <= i;
        regWrMode <= m;
        regWrData <= d;
        regRdIdx <= i;
        @(posedge clk);
        regWrEn <= 1'h0;
        tick(2);
        chk(regRdData, e);
    endtask
    task automatic alu(input logic [31:0] a, input logic [31:0] b, input logic [3:0] e);
        @(posedge clk);
        aluGo <= 1'h1;
        opA <= a;
        opB <= b;
        @(posedge clk);
        aluGo <= 1'h0;
        tick(3);
        chk({flagsOut[5], flagsOut[3:2], flagsOut[0]}, e);
    endtask
    task automatic req(input logic [2:0] lv, input logic e);
        @(posedge clk);
        irqReqEn <= 1'h1;
        irqReqLevel <= lv;
        @(posedge clk);
        irqReqEn <= 1'h0;
        tick(1);
        chk(irqAdmit, e);
    endtask
    // flags: enable, user stack, level 3; then accept
    task automatic intr(input logic hw, input logic [7:0] n, input logic [1:0] e);
        apb(OFS_FLAGS, 1'h1, 32'h30C0);
        @(posedge clk);
        intAccept <= 1'h1;
        intHw <= hw;
        intSwNum <= n;
        @(posedge clk);
        intAccept <= 1'h0;
        tick(2);
        chk(flagsOut[7:6], e);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard: run needs under 1000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            finish_test();
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        tick(5);
        rst_n <= 1'h1;
        apb(OFS_FLAGS, 1'h0, 32'h0);
        chk(rd, FLAGS_RST);
        foreach (rows[k]) begin
            apb(rows[k].a, 1'h1, rows[k].w);
            chk(err, rows[k].e);
            apb(rows[k].a, 1'h0, 32'h0);
            chk({rd[31:1], rd[0] ^ err}, rows[k].r ^ rows[k].e);
        end
        $display("register rows done");
        chk(vecBaseOut, 32'hFFFF0000);
        chk(roundMode, 2'h3);
        chk(radixPoint, 1'h1);
        chk(stackPtr, 32'h100);
        @(posedge clk);
        pushEn <= 1'h1;
        @(posedge clk);
        pushEn <= 1'h0;
        tick(1);
        chk(stackPtr, 32'hFC);
        apb(OFS_IRQ_SP, 1'h0, 32'h0);
        chk(rd, 32'h200);
        req(3'h7, 1'h0);
        apb(OFS_FLAGS, 1'h1, 32'h30C0);
        for (int lv = 0; lv < 8; lv++) begin
            req(lv[2:0], lv > 3);
        end
        intr(1'h0, 8'hC8, 2'h2);
        intr(1'h0, 8'h7F, 2'h0);
        intr(1'h1, 8'hC8, 2'h0);
        chk(stackPtr, 32'h200);
        $display("interrupt flags done");
        regw(4'h0, WR_BYTE0, 32'h0, 32'h12345600);
        @(posedge clk);
        bankSelEn <= 1'h1;
        bankSelVal <= 1'h1;
        @(posedge clk);
        bankSelEn <= 1'h0;
        tick(2);
        chk(flagsOut[4], 1'h1);
        regw(4'h0, WR_WORD, 32'h11223344, 32'h11223344);
        regw(4'h0, WR_HI16, 32'hAAAA0000, 32'hAAAA3344);
        regw(4'h0, WR_LO16, 32'h5566, 32'hAAAA5566);
        regw(4'h0, WR_BYTE1, 32'hBB00, 32'hAAAABB66);
        regw(4'h1, WR_BYTE2, 32'hCC0000, 32'h9ACCDEF0);
        regw(4'h1, WR_BYTE3, 32'hDD000000, 32'hDDCCDEF0);
        regw(4'h2, WR_BYTE0, 32'h55, 32'h0);
        apb(8'h50, 1'h1, 32'h2000);
        agenRelative <= 1'h1;
        agenDisp <= 32'h20;
        tick(3);
        chk(agenAddr, 32'h2020);
        alu(32'hFFFFFFFF, 32'h1, 4'h3);
        alu(32'h7FFFFFFF, 32'h1, 4'hC);
        @(posedge clk);
        fpFlagEn <= 1'h1;
        fpUnder <= 1'h1;
        @(posedge clk);
        fpFlagEn <= 1'h0;
        tick(2);
        chk(flagsOut[9:8], 2'h1);
        $display("bank and flag updates done");
        @(posedge clk);
        pcLoadEn <= 1'h1;
        pcLoadVal <= 32'h1234;
        @(posedge clk);
        pcLoadEn <= 1'h0;
        fastIntEn <= 1'h1;
        @(posedge clk);
        fastIntEn <= 1'h0;
        tick(1);
        chk(pcOut, 32'h5000);
        apb(OFS_SAVED_PC, 1'h0, 32'h0);
        chk(rd, 32'h1234);
        apb(OFS_SAVED_FLAGS, 1'h0, 32'h0);
        chk(rd, 32'h3138);
        fastRetEn <= 1'h1;
        @(posedge clk);
        fastRetEn <= 1'h0;
        tick(1);
        chk(pcOut, 32'h1234);
        $display("fast interrupt done");
        finish_test();
    end
endmodule
